/* testbench/board_model.sv */
// board_model: other chips on the board facing the crosspoint pins
// assumes the bench sets drv; a pin the device drives shows the device level
`timescale 1ns/1ns
module board_model #(
	parameter int unsigned N_PINS = 80
)(
	input  wire logic [N_PINS-1:0] drv,
	input  wire logic [N_PINS-1:0] pin_out,
	input  wire logic [N_PINS-1:0] pin_oe,
	output logic      [N_PINS-1:0] pin_in
);
	// board side lets go wherever the device drives, so no fight on the wire
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
endmodule : board_model

/* testbench/crosspoint_io_cell_router_sva.sv */
// crosspoint_io_cell_router_chk: bus handshake and pin enable checks
// assumes bind onto the top module, single clock aclk
`timescale 1ns/1ns
module crosspoint_io_cell_router_chk #(
	parameter int unsigned N_PINS = 80
)(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              power_good,
	input wire logic [N_PINS-1:0] pin_oe,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_power_off: assert property (!power_good |=> pin_oe == '0) else $error("pins driven without power");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write response");
	a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stays up");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid repeats");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("no read response");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid repeats");
endmodule : crosspoint_io_cell_router_chk

bind crosspoint_io_cell_router crosspoint_io_cell_router_chk #(.N_PINS(N_PINS)) u_chk (.aclk(aclk),
	.aresetn(aresetn), .power_good(power_good), .pin_oe(pin_oe), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* testbench/tb_crosspoint_io_cell_router.sv */
// tb_crosspoint_io_cell_router: bus tasks and pin scenarios, self-checking
// assumes board_model drives every pin the device leaves undriven
`timescale 1ns/1ns
module tb_crosspoint_io_cell_router;
	import crosspoint_pkg::*;
	logic              aclk = 0;
	logic              aresetn = 0;
	logic              erase_n = 0;
	logic              power_good = 1;
	logic [79:0]       drv = '0;
	logic [79:0]       pin_in, pin_out, pin_oe;
	logic [1:0]        gpin = 2'h1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, rd;
	logic [1:0]        bresp, rresp, rs;
	logic              awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic              arvalid = 0, arready, rvalid, rready = 0;
	int                n_fail = 0, checks = 0, cyc = 0;
	int                pins [4] = '{0, 20, 41, 60};
	int                pick [4] = '{0, 1, 3, 2};
	always #2 aclk = ~aclk;
	crosspoint_io_cell_router #(.N_PINS(80)) u_dut (.aclk(aclk), .aresetn(aresetn), .cfg_erase_n(erase_n),
		.power_good(power_good), .pin_in(pin_in), .global_clock_gate_pin(gpin), .pin_out(pin_out),
		.pin_oe(pin_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	board_model #(.N_PINS(80)) u_board (.drv(drv), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
	task automatic give_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) chk(32'(bresp), 32'(er));
			bready <= bvalid && !bready;
		end
		while (!(bvalid && bready));
	endtask : wr
	task automatic rd_word(input logic [ADDR_W-1:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) rd = rdata;
			if (rvalid && rready) rs = rresp;
			rready <= rvalid && !rready;
		end
		while (!(rvalid && rready));
	endtask : rd_word
	// same words into cells 40 and 44: one input pin fans out to two outputs
	task automatic cfg(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] m);
		int cells [2] = '{40, 44};
		foreach (cells[i])
		begin
			wr(ADDR_W'(cells[i] * 16), 32'h0040_0e40, RESP_OKAY);
			wr(ADDR_W'(cells[i] * 16 + 4), s, RESP_OKAY);
			wr(ADDR_W'(cells[i] * 16 + 8), m, RESP_OKAY);
		end
	endtask : cfg
	task automatic pchk(input logic v, input logic oe);
		repeat (4) @(posedge aclk);
		chk(32'(pin_out[40]), 32'(v));
		chk(32'(pin_out[44]), 32'(v));
		chk(32'(pin_oe[40]), 32'(oe));
	endtask : pchk
	task automatic tick();
		@(posedge aclk);
		drv[50] <= 1'b1;
		repeat (3) @(posedge aclk);
		drv[50] <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : tick
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (20) @(posedge aclk);
		chk(32'(|pin_oe), 32'h0);
		aresetn <= 1'b1;
		erase_n <= 1'b1;
		// reserved select bits read back as zero, unmapped space refused
		wr(12'h014, 32'hffff_ffff, RESP_OKAY);
		rd_word(12'h014);
		chk(rd, SELECT_MASK);
		wr(12'hf00, 32'h1, RESP_SLVERR);
		rd_word(12'hf00);
		chk(32'(rs), 32'(RESP_SLVERR));
		chk(rd, 32'h0);
		cfg(32'h81, 32'h20);
		for (int c = 0; c < 4; c++)
			for (int v = 0; v < 2; v++)
			begin
				@(posedge aclk);
				for (int j = 0; j < 4; j++) drv[pins[j]] <= (j == pick[c]) ? v[0] : !v[0];
				drv[1] <= c[0];
				drv[2] <= c[1];
				pchk(v[0], 1'b1);
			end
		cfg(32'h81, 32'h1020);
		pchk(1'b0, 1'b1);
		cfg(32'h81, 32'h30020);
		pchk(1'b1, 1'b1);
		cfg(32'h81, 32'h11020);
		pchk(1'b0, 1'b1);
		cfg(32'h81, 32'h45);
		drv[65] <= 1'b1;
		pchk(1'b1, 1'b1);
		drv[65] <= 1'b0;
		pchk(1'b1, 1'b0);
		cfg(32'h81, 32'hc5);
		pchk(1'b1, 1'b1);
		power_good <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(32'(|pin_oe), 32'h0);
		power_good <= 1'b1;
		// edge register on clock pin 50, gate from global pin 0
		drv[2:0] <= 3'b001;
		cfg(32'h0100_a081, 32'h2020);
		tick();
		pchk(1'b1, 1'b1);
		drv[0] <= 1'b0;
		pchk(1'b1, 1'b1);
		gpin <= 2'h0;
		tick();
		pchk(1'b1, 1'b1);
		gpin <= 2'h1;
		tick();
		pchk(1'b0, 1'b1);
		cfg(32'h0100_a081, 32'h4020);
		drv[50] <= 1'b1;
		pchk(1'b0, 1'b1);
		drv[0] <= 1'b1;
		pchk(1'b1, 1'b1);
		drv[50] <= 1'b0;
		repeat (2) @(posedge aclk);
		drv[0] <= 1'b0;
		pchk(1'b1, 1'b1);
		// cell 42 cascades cell 40's selector through expansion input zero
		wr(12'h2a0, 32'h1, RESP_OKAY);
		wr(12'h2a8, 32'h20, RESP_OKAY);
		drv[2:1] <= 2'b11;
		pchk(1'b1, 1'b1);
		chk(32'(pin_out[42]), 32'h1);
		// cell 41 registers its own pin into the pool, then the pin drops
		wr(12'h294, 32'h0100_a000, RESP_OKAY);
		wr(12'h298, 32'ha000, RESP_OKAY);
		tick();
		drv[41] <= 1'b0;
		rd_word(12'h804);
		chk(rd, 32'h0000_1500);
		rd_word(12'h824);
		chk(rd, 32'h0000_1300);
		chk(32'(pin_out[42]), 32'h1);
		give_verdict();
	end
endmodule : tb_crosspoint_io_cell_router

/* verilog/crosspoint_io_cell.sv */
// crosspoint_io_cell: one I/O cell - selector, crossbar, storage element, polarity
// assumes pin levels and pool are synchronous to aclk; configuration is static
`timescale 1ns/1ns
module crosspoint_io_cell #(
	parameter int unsigned N_PINS = 80
)(
	input  wire logic                                     aclk,
	input  wire logic                                     aresetn,
	input  wire crosspoint_pkg::cell_route_t              route,
	input  wire crosspoint_pkg::cell_select_t             sel,
	input  wire crosspoint_pkg::cell_misc_t               misc,
	input  wire logic [N_PINS-1:0]                        pool,
	input  wire logic [3:0]                               nbr,
	input  wire logic                                     pin_level,
	input  wire logic [crosspoint_pkg::GLOBAL_PINS-1:0]   global_pin,
	output logic                                          pool_bit,
	output logic                                          drive_val,
	output logic                                          drive_en,
	output logic                                          mux_q,
	output logic                                          stored
);
	import crosspoint_pkg::*;

	localparam int unsigned QUARTER = N_PINS / 4;

	// index past the quarter falls back to its first pin
	function automatic logic pick(input logic [N_PINS-1:0] p, input int unsigned set,
		input logic [IDX_W-1:0] idx);
		int unsigned pos;
		pos = set * QUARTER + ((32'(idx) < QUARTER) ? 32'(idx) : 32'd0);
		return p[pos];
	endfunction : pick

	logic [3:0] direct;
	logic [3:0] raw;
	logic [3:0] m;
	logic       sel_lo;
	logic       sel_hi;
	logic       mux_val;
	logic       eclk;
	logic       ecen;
	logic       d_in;
	logic       path_val;
	logic       clk_prev_ff;
	logic       store_ff;
	logic       mux_q_ff;

	always_comb
	begin
		for (int unsigned i = 0; i < 4; i++)
		begin
			direct[i] = pick(pool, i, route.src_idx[i]); // RQ7
			raw[i] = route.expand_en[i] ? nbr[i] : direct[i]; // RQ9
		end
		for (int unsigned i = 0; i < 4; i++)
			m[i] = raw[route.xbar[i]]; // RQ18
	end

	assign sel_lo = (sel.sel_lo_set ? pick(pool, SET_SEL_TWO, sel.sel_lo_idx)
		: pick(pool, SET_SEL_ONE, sel.sel_lo_idx)) ^ misc.inv_lo; // RQ8 RQ3
	assign sel_hi = (sel.sel_hi_set ? pick(pool, SET_SEL_TWO, sel.sel_hi_idx)
		: pick(pool, SET_SEL_ONE, sel.sel_hi_idx)) ^ misc.inv_hi; // RQ8 RQ3

	always_comb
	begin
		case ({sel_hi, sel_lo}) // RQ1
			2'b00:   mux_val = m[0];
			2'b01:   mux_val = m[1];
			2'b11:   mux_val = m[2];
			2'b10:   mux_val = m[3];
			default: mux_val = m[0];
		endcase
	end

	// clock and gate share the clock set and the global pins
	assign eclk = (sel.clk_global ? global_pin[sel.clk_pick]
		: pick(pool, SET_CLOCK, sel.clk_idx)) ^ misc.inv_clk; // RQ13 RQ19 RQ20 RQ3
	assign ecen = (sel.cen_global ? global_pin[sel.cen_pick]
		: pick(pool, SET_CLOCK, sel.cen_idx)) ^ misc.inv_cen; // RQ14 RQ19 RQ20 RQ3

	assign d_in = misc.in_path ? pin_level : mux_val; // RQ10 RQ11

	// pin clock is sampled; tracked through reset so a high level at release is no edge
	always_ff @(posedge aclk)
	begin
		clk_prev_ff <= eclk;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			store_ff <= 1'b0;
		else if (misc.store_mode == STORE_REG && eclk && !clk_prev_ff && ecen) // RQ12 RQ2
			store_ff <= d_in;
		else if (misc.store_mode == STORE_LATCH && eclk && ecen) // RQ22 RQ2
			store_ff <= d_in;
	end

	// registered copy breaks combinational loops through circular cascades
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mux_q_ff <= 1'b0;
		else
			mux_q_ff <= mux_val;
	end

	always_comb
	begin
		if (misc.in_path)
			path_val = mux_val;
		else if (misc.store_mode == STORE_BYPASS || misc.store_mode == STORE_RSVD)
			path_val = mux_val; // RQ15
		else
			path_val = store_ff; // RQ10
		pool_bit = (misc.in_path && misc.store_mode != STORE_BYPASS
			&& misc.store_mode != STORE_RSVD) ? store_ff : pin_level; // RQ11
		drive_val = misc.const_en ? misc.const_val : (path_val ^ misc.inv_out); // RQ5 RQ16
		case (misc.oe_mode)
			OE_ON:   drive_en = 1'b1;
			OE_PIN:  drive_en = pick(pool, SET_OE, misc.oe_idx) ^ misc.inv_oe; // RQ17 RQ3
			default: drive_en = 1'b0;
		endcase
	end

	assign mux_q  = mux_q_ff;
	assign stored = store_ff;

endmodule : crosspoint_io_cell

/* verilog/crosspoint_io_cell_router.sv */
// crosspoint_io_cell_router: crosspoint of identical I/O cells around a routing pool
// assumes synchronous pins, AXI4-Lite configuration access, power_good from supply monitor
//
// Overview of operation
// RQ1: selector picks input 0,1,2,3 for select codes 00,01,11,10 (high,low).
// RQ2: a storage element holds its value while its effective gate enable is 0.
// RQ3: each cell may invert its output enable, clock, gate and both select inputs.
// RQ4: any input pin can reach one or many output pins with no restriction.
// RQ5: an output pin may drive a configured constant high or low level.
// RQ6: all pin drivers stay off while power is not good; pin_oe clears one aclk cycle after power_good falls.
// RQ7: each selector data input takes one pin from its own quarter.
// RQ8: each select bit comes from either of two quarter-sized select pin sets.
// RQ9: selector inputs may take neighbours' selector outputs, two above, two below.
// RQ10: output placement stores the selector result and drives the pin.
// RQ11: input placement stores the pin level and feeds the routing pool.
// RQ12: storage element is an edge register, a flow-through latch, or bypassed.
// RQ13: storage clock comes from the clock pin set or a global clock pin.
// RQ14: gate enable comes from the clock pin set or a global gate pin.
// RQ15: a configuration bit bypasses storage for a combinational output.
// RQ16: each cell output is active high or inverted.
// RQ17: each pin's enable is independent, taken from the output-enable pin set.
// RQ18: each cell has a configured four-by-four crossbar before the selector.
// RQ19: global clock pin k also serves as global gate enable pin k.
// RQ20: clock and gate enable draw on one shared pin set.
// RQ21: configuration survives functional reset; only the erase input clears it.
// RQ22: latch passes input while clock is active, holds while inactive.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module crosspoint_io_cell_router #(
	parameter int unsigned N_PINS = 80
)(
	input  wire logic                                     aclk,
	input  wire logic                                     aresetn,
	input  wire logic                                     cfg_erase_n,
	input  wire logic                                     power_good,
	input  wire logic [N_PINS-1:0]                        pin_in,
	input  wire logic [crosspoint_pkg::GLOBAL_PINS-1:0]   global_clock_gate_pin,
	output logic      [N_PINS-1:0]                        pin_out,
	output logic      [N_PINS-1:0]                        pin_oe,
	input  wire logic [crosspoint_pkg::ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                                     s_axi_awvalid,
	output logic                                          s_axi_awready,
	input  wire logic [crosspoint_pkg::DATA_W-1:0]        s_axi_wdata,
	input  wire logic [crosspoint_pkg::STRB_W-1:0]        s_axi_wstrb,
	input  wire logic                                     s_axi_wvalid,
	output logic                                          s_axi_wready,
	output logic      [1:0]                               s_axi_bresp,
	output logic                                          s_axi_bvalid,
	input  wire logic                                     s_axi_bready,
	input  wire logic [crosspoint_pkg::ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                                     s_axi_arvalid,
	output logic                                          s_axi_arready,
	output logic      [crosspoint_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic      [1:0]                               s_axi_rresp,
	output logic                                          s_axi_rvalid,
	input  wire logic                                     s_axi_rready
);
	import crosspoint_pkg::*;

	localparam int unsigned STATUS_WORDS = (N_PINS + 31) / 32;

	if (N_PINS % 4 != 0 || N_PINS / 4 > 32 || N_PINS > 128 || N_PINS < 8)
	begin : g_bad_size
		$error("N_PINS must be a multiple of four between 8 and 128");
	end

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word, input logic [STRB_W-1:0] strb);
		logic [DATA_W-1:0] res;
		res = old_word;
		for (int unsigned b = 0; b < STRB_W; b++)
		begin
			if (strb[b])
				res[b*8 +: 8] = new_word[b*8 +: 8];
		end
		return res;
	endfunction : merge

	// configuration store
	cell_route_t  route_ff  [N_PINS];
	cell_select_t select_ff [N_PINS];
	cell_misc_t   misc_ff   [N_PINS];

	// bus slave state
	logic                  awready_ff;
	logic                  wready_ff;
	logic                  aw_got_ff;
	logic                  w_got_ff;
	logic [ADDR_W-1:0]     awaddr_ff;
	logic [DATA_W-1:0]     wdata_ff;
	logic [STRB_W-1:0]     wstrb_ff;
	logic                  bvalid_ff;
	logic [1:0]            bresp_ff;
	logic                  arready_ff;
	logic                  rvalid_ff;
	logic [DATA_W-1:0]     rdata_ff;
	logic [1:0]            rresp_ff;

	// pin side
	logic [N_PINS-1:0]     pin_out_ff;
	logic [N_PINS-1:0]     pin_oe_ff;
	logic [N_PINS-1:0]     global_routing_pool;
	logic [N_PINS-1:0]     cell_drive;
	logic [N_PINS-1:0]     cell_en;
	logic [N_PINS-1:0]     cell_mux_q;
	logic [N_PINS-1:0]     cell_stored;

	// decode
	logic                  wr_fire;
	logic [CELL_W-1:0]     wr_cell;
	logic [1:0]            wr_word;
	logic                  wr_is_cell;
	logic [CELL_W-1:0]     rd_cell;
	logic [1:0]            rd_word;
	logic                  rd_is_cell;
	logic                  rd_is_status;
	logic [2:0]            rd_status_word;
	logic [DATA_W-1:0]     nxt_rdata;
	logic [1:0]            nxt_rresp;
	logic [1:0]            nxt_bresp;
	logic [STATUS_WORDS*32-1:0] pin_pad;
	logic [STATUS_WORDS*32-1:0] store_pad;

	// cell array; every input pin enters the pool, so any pin can fan out to many
	for (genvar n = 0; n < N_PINS; n++)
	begin : g_cell
		logic [3:0] nbr;
		assign nbr[0] = cell_mux_q[(n + N_PINS + NBR_OFF_0) % N_PINS]; // RQ9
		assign nbr[1] = cell_mux_q[(n + N_PINS + NBR_OFF_1) % N_PINS]; // RQ9
		assign nbr[2] = cell_mux_q[(n + N_PINS + NBR_OFF_2) % N_PINS]; // RQ9
		assign nbr[3] = cell_mux_q[(n + N_PINS + NBR_OFF_3) % N_PINS]; // RQ9

		crosspoint_io_cell #(
			.N_PINS (N_PINS)
		) u_cell (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.route      (route_ff[n]),
			.sel        (select_ff[n]),
			.misc       (misc_ff[n]),
			.pool       (global_routing_pool),
			.nbr        (nbr),
			.pin_level  (pin_in[n]),
			.global_pin (global_clock_gate_pin),
			.pool_bit   (global_routing_pool[n]), // RQ4
			.drive_val  (cell_drive[n]),
			.drive_en   (cell_en[n]),
			.mux_q      (cell_mux_q[n]),
			.stored     (cell_stored[n])
		);
	end

	// drivers are held off until the supply monitor reports good power
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_oe_ff  <= '0;
			pin_out_ff <= '0;
		end
		else
		begin
			pin_oe_ff  <= power_good ? cell_en : '0; // RQ6
			pin_out_ff <= cell_drive;
		end
	end

	assign pin_out = pin_out_ff;
	assign pin_oe  = pin_oe_ff;

	// write channel
	assign wr_fire    = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wr_cell    = awaddr_ff[10:4];
	assign wr_word    = awaddr_ff[3:2];
	assign wr_is_cell = (awaddr_ff[11] == 1'b0) && (32'(wr_cell) < N_PINS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			awready_ff <= 1'b0;
		else if (s_axi_awvalid && awready_ff)
			awready_ff <= 1'b0;
		else if (!aw_got_ff && !bvalid_ff)
			awready_ff <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wready_ff <= 1'b0;
		else if (s_axi_wvalid && wready_ff)
			wready_ff <= 1'b0;
		else if (!w_got_ff && !bvalid_ff)
			wready_ff <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			awaddr_ff <= '0;
		end
		else if (s_axi_awvalid && awready_ff)
		begin
			aw_got_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_got_ff <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_got_ff <= 1'b0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end
		else if (s_axi_wvalid && wready_ff)
		begin
			w_got_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_got_ff <= 1'b0;
	end

	// status and spare words accept writes silently; unmapped addresses error
	always_comb
	begin
		if (wr_is_cell)
			nxt_bresp = RESP_OKAY;
		else if (awaddr_ff[ADDR_W-1:6] == STATUS_TAG)
			nxt_bresp = RESP_OKAY;
		else
			nxt_bresp = RESP_SLVERR;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= nxt_bresp;
		end
		else if (bvalid_ff && s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// configuration ignores aresetn, mimicking retained storage
	always_ff @(posedge aclk)
	begin
		if (!cfg_erase_n)
		begin
			for (int unsigned c = 0; c < N_PINS; c++)
			begin
				route_ff[c]  <= cell_route_t'(CFG_RESET); // RQ21
				select_ff[c] <= cell_select_t'(CFG_RESET);
				misc_ff[c]   <= cell_misc_t'(CFG_RESET);
			end
		end
		else if (wr_fire && wr_is_cell)
		begin
			case (wr_word)
				WORD_ROUTE:
					route_ff[wr_cell] <= cell_route_t'(merge(route_ff[wr_cell], wdata_ff, wstrb_ff));
				WORD_SELECT:
					select_ff[wr_cell] <= cell_select_t'(merge(select_ff[wr_cell], wdata_ff, wstrb_ff)
						& SELECT_MASK);
				WORD_MISC:
					misc_ff[wr_cell] <= cell_misc_t'(merge(misc_ff[wr_cell], wdata_ff, wstrb_ff)
						& MISC_MASK);
				default:
					misc_ff[wr_cell] <= misc_ff[wr_cell];
			endcase
		end
	end

	// read channel
	assign rd_cell        = s_axi_araddr[10:4];
	assign rd_word        = s_axi_araddr[3:2];
	assign rd_is_cell     = (s_axi_araddr[11] == 1'b0) && (32'(rd_cell) < N_PINS);
	assign rd_is_status   = (s_axi_araddr[ADDR_W-1:6] == STATUS_TAG);
	assign rd_status_word = s_axi_araddr[4:2];

	always_comb
	begin
		pin_pad   = '0;
		store_pad = '0;
		pin_pad[N_PINS-1:0]   = pin_in;
		store_pad[N_PINS-1:0] = cell_stored;
	end

	always_comb
	begin
		nxt_rdata = '0;
		nxt_rresp = RESP_OKAY;
		if (rd_is_cell)
		begin
			case (rd_word)
				WORD_ROUTE:  nxt_rdata = route_ff[rd_cell];
				WORD_SELECT: nxt_rdata = select_ff[rd_cell];
				WORD_MISC:   nxt_rdata = misc_ff[rd_cell];
				default:     nxt_rdata = '0;
			endcase
		end
		else if (rd_is_status)
		begin
			if (32'(rd_status_word) < STATUS_WORDS)
			begin
				if (s_axi_araddr[5] == STATUS_STORE_OFF[5])
					nxt_rdata = store_pad[32'(rd_status_word)*32 +: 32];
				else
					nxt_rdata = pin_pad[32'(rd_status_word)*32 +: 32];
			end
		end
		else
			nxt_rresp = RESP_SLVERR;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			arready_ff <= 1'b0;
		else if (s_axi_arvalid && arready_ff)
			arready_ff <= 1'b0;
		else if (!rvalid_ff)
			arready_ff <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_ff)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

endmodule : crosspoint_io_cell_router

/* verilog/crosspoint_pkg.sv */
// crosspoint_pkg: shared constants, register map and configuration word layouts
// assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock (aclk)
package crosspoint_pkg;

	// bus geometry
	localparam int unsigned ADDR_W         = 12;
	localparam int unsigned DATA_W         = 32;
	localparam int unsigned STRB_W         = DATA_W / 8;
	localparam int unsigned IDX_W          = 5;
	localparam int unsigned CELL_W         = 7;
	localparam int unsigned GLOBAL_PINS    = 2;

	// register map: one 16-byte slot per cell, status block above it
	localparam logic [ADDR_W-1:0] CELL_BASE        = 12'h000;
	localparam logic [ADDR_W-1:0] CELL_STRIDE      = 12'h010;
	localparam logic [1:0]        WORD_ROUTE       = 2'h0;
	localparam logic [1:0]        WORD_SELECT      = 2'h1;
	localparam logic [1:0]        WORD_MISC        = 2'h2;
	localparam logic [1:0]        WORD_SPARE       = 2'h3;
	localparam logic [ADDR_W-1:0] STATUS_PIN_OFF   = 12'h800;
	localparam logic [ADDR_W-1:0] STATUS_STORE_OFF = 12'h820;
	localparam logic [5:0]        STATUS_TAG       = 6'h20;

	// reserved bits of the select and misc words read as zero
	localparam logic [DATA_W-1:0] SELECT_MASK      = 32'h03ff_ffff;
	localparam logic [DATA_W-1:0] MISC_MASK        = 32'h0003_ffff;
	localparam logic [DATA_W-1:0] CFG_RESET        = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// designated pin sets, each one quarter of all pins
	localparam int unsigned SET_SEL_ONE = 0;
	localparam int unsigned SET_SEL_TWO = 1;
	localparam int unsigned SET_CLOCK   = 2;
	localparam int unsigned SET_OE      = 3;

	// neighbour offsets feeding selector inputs zero..three, circular
	localparam int NBR_OFF_0 = -2;
	localparam int NBR_OFF_1 = -1;
	localparam int NBR_OFF_2 = 1;
	localparam int NBR_OFF_3 = 2;

	typedef enum logic [1:0] {
		STORE_BYPASS = 2'b00,
		STORE_REG    = 2'b01,
		STORE_LATCH  = 2'b10,
		STORE_RSVD   = 2'b11
	} store_mode_t;

	typedef enum logic [1:0] {
		OE_OFF  = 2'b00,
		OE_ON   = 2'b01,
		OE_PIN  = 2'b10,
		OE_RSVD = 2'b11
	} oe_mode_t;

	typedef struct packed {
		logic [3:0][IDX_W-1:0] src_idx;
		logic [3:0][1:0]       xbar;
		logic [3:0]            expand_en;
	} cell_route_t;

	typedef struct packed {
		logic [5:0]       pad;
		logic             cen_pick;
		logic             cen_global;
		logic [IDX_W-1:0] cen_idx;
		logic             clk_pick;
		logic             clk_global;
		logic [IDX_W-1:0] clk_idx;
		logic             sel_hi_set;
		logic [IDX_W-1:0] sel_hi_idx;
		logic             sel_lo_set;
		logic [IDX_W-1:0] sel_lo_idx;
	} cell_select_t;

	typedef struct packed {
		logic [13:0]      pad;
		logic             const_val;
		logic             const_en;
		logic             in_path;
		store_mode_t      store_mode;
		logic             inv_out;
		logic             inv_hi;
		logic             inv_lo;
		logic             inv_cen;
		logic             inv_clk;
		logic             inv_oe;
		oe_mode_t         oe_mode;
		logic [IDX_W-1:0] oe_idx;
	} cell_misc_t;

endpackage : crosspoint_pkg
